// [inc/irq_retry_pkg.sv]
// Constants, field layouts and carrier types for the common interrupt and retry block
package irq_retry_pkg;
   localparam int          ADDR_W            = 16;
   localparam int          DATA_W            = 8;
   // ***********************************************************
   // Register byte offsets, high byte of wide registers first
   // ***********************************************************
   localparam logic [15:0] OFS_COMMON_FLAGS  = 16'h0015;
   localparam logic [15:0] OFS_SOCK_MASK     = 16'h0016;
   localparam logic [15:0] OFS_RTR_HI        = 16'h0017;
   localparam logic [15:0] OFS_RTR_LO        = 16'h0018;
   localparam logic [15:0] OFS_RETRY_COUNT   = 16'h0019;
   localparam logic [15:0] OFS_AUTH_HI       = 16'h001C;
   localparam logic [15:0] OFS_AUTH_LO       = 16'h001D;
   localparam logic [15:0] OFS_AUTH_ALGO     = 16'h001E;
   localparam logic [15:0] OFS_CHIP_REV      = 16'h001F;
   localparam logic [15:0] OFS_LCP_INTERVAL  = 16'h0028;
   localparam logic [15:0] OFS_LCP_MAGIC     = 16'h0029;
   localparam logic [15:0] OFS_WAIT_HI       = 16'h0030;
   localparam logic [15:0] OFS_WAIT_LO       = 16'h0031;
   localparam logic [15:0] OFS_SOCK_SUMMARY  = 16'h0034;
   localparam logic [15:0] OFS_COMMON_MASK   = 16'h0036;
   // ***********************************************************
   // Fields and reset values
   // ***********************************************************
   localparam int          BIT_IP_CONFLICT   = 7;
   localparam int          BIT_PPP_CLOSE     = 5;
   localparam logic [7:0]  COMMON_VALID      = 8'hA0;
   localparam logic [15:0] RST_RTR           = 16'h07D0;
   localparam logic [7:0]  RST_RETRY_COUNT   = 8'h08;
   localparam logic [15:0] RST_ZERO16        = 16'h0000;
   localparam logic [7:0]  RST_ZERO8         = 8'h00;
   localparam logic [15:0] AUTH_PAP          = 16'hC023;
   localparam logic [15:0] AUTH_CHAP         = 16'hC223;
   localparam logic [16:0] RTR_CAP           = 17'h0FFFF;
   // ***********************************************************
   // Timing
   // ***********************************************************
   localparam int          CLK_PERIOD_NS     = 5;
   localparam int          TICK_US           = 100;
   localparam int          TICK_CYCLES_DEF   = (TICK_US * 1000) / CLK_PERIOD_NS;
   localparam int          LCP_UNIT_MS       = 25;
   localparam logic [7:0]  LCP_TICKS         = 8'((LCP_UNIT_MS * 1000) / TICK_US);
   // ***********************************************************
   // Carriers
   // ***********************************************************
   typedef struct packed {
      logic              wr;
      logic              rd;
      logic [15:0]       addr;
      logic [7:0]        wdata;
   } reg_req_t;
   typedef struct packed {
      logic              start;
      logic              is_tcp;
      logic              ack;
   } retry_ctl_t;
   typedef struct packed {
      logic              retransmit;
      logic              timeout;
      logic              tcp_close;
      logic              busy;
   } retry_stat_t;
   typedef struct packed {
      logic              load;
      logic [15:0]       auth_type;
      logic [7:0]        algo;
   } ppp_info_t;
   typedef enum logic {RS_IDLE, RS_WAIT} retry_state_t;
endpackage : irq_retry_pkg

// [rtl/irq_retry_ctrl.sv]
// Common interrupt aggregation, reassert wait, retry timer, PPPoE info registers
// Overview of operation
// - Interrupt pin asserts when a common flag is set and its mask bit is one.
// - A zero mask bit blocks the interrupt though the flag still sets.
// - Sixteen-bit retry period in 100us units, reset to 2000 (200ms).
// - Retransmit when the peer does not answer or answers late after commands.
// - Eight-bit retry count, reset 8; final timeout after count plus one periods.
// - TCP final timeout closes the socket together with its timeout flag.
// - Hardware address request repeats each period, count plus one periods in all.
// - Unacknowledged TCP segments retransmit each timeout, then final timeout.
// - TCP period doubles per retransmission until doubling would pass 65535.
// - Read-only authentication type, 0xC023 or 0xC223, resets to zero.
// - Read-only authentication algorithm register, resets to zero.
// - Read-only fixed chip revision code.
// - Echo requests sent every interval count of roughly 25ms.
// - Writable magic value, reset zero, used in link negotiation.
// - Sixteen-bit reassert wait register, reset zero.
// - After release with sources pending, reassert after wait plus one clocks.
// - Socket summary bit n sets on socket n interrupt; masked bit drives pin.
// - Summary bit clears once socket flags are all zero; pin then releases.
// - Flag 7 sets on address conflict, flag 5 on PPPoE close; write one clears.
// - Pin stays low while any unmasked common flag stays set and no other unmasked source drops.
// - Eight-bit socket mask; bit n enables summary bit n onto the pin.
module irq_retry_ctrl #(
   parameter int TICK_CYCLES = irq_retry_pkg::TICK_CYCLES_DEF,
   parameter logic [7:0] CHIP_REV_CODE = 8'h5A // Arbitrary value
) (
   input  wire logic                       ref_clk,
   input  wire logic                       arst_n,
   input  wire irq_retry_pkg::reg_req_t    bus_req,
   output logic [7:0]                      rdata,
   input  wire logic                       ip_conflict_evt,
   input  wire logic                       ppp_close_evt,
   input  wire logic [7:0]                 sock_irq_evt,
   input  wire logic [7:0]                 sock_irq_any,
   input  wire irq_retry_pkg::ppp_info_t   ppp_info,
   input  wire logic                       ppp_mode,
   input  wire irq_retry_pkg::retry_ctl_t  retry_ctl,
   output irq_retry_pkg::retry_stat_t      retry_stat,
   output logic                            lcp_echo_req,
   output logic [7:0]                      lcp_magic,
   output logic                            irq_out_n
);
   import irq_retry_pkg::*;

   localparam int TICK_W = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;

   function automatic logic wr_at(input reg_req_t r, input logic [15:0] ofs);
      return r.wr && (r.addr == ofs);
   endfunction : wr_at

   // ***********************************************************
   // Registers
   // ***********************************************************
   logic [7:0]   common_irq_flags_ff;
   logic [7:0]   common_irq_mask_ff;
   logic [7:0]   socket_irq_mask_ff;
   logic [7:0]   socket_irq_summary_ff;
   logic [15:0]  retry_timeout_value_ff;
   logic [7:0]   retry_count_ff;
   logic [15:0]  ppp_auth_type_ff;
   logic [7:0]   ppp_auth_algorithm_ff;
   logic [7:0]   lcp_echo_interval_ff;
   logic [7:0]   lcp_magic_value_ff;
   logic [15:0]  irq_reassert_wait_ff;
   logic [7:0]   rdata_ff;
   logic [7:0]   nxt_rdata;
   logic [7:0]   nxt_common_irq_flags;
   logic [7:0]   nxt_socket_irq_summary;
   logic [7:0]   flag_clear;
   logic [7:0]   flag_set;
   logic [7:0]   sock_drop;

   assign flag_clear = wr_at(bus_req, OFS_COMMON_FLAGS) ? bus_req.wdata : 8'h00;
   assign flag_set   = {ip_conflict_evt, 1'b0, ppp_close_evt, 5'h00};
   // Set beats a same-cycle write-one clear
   assign nxt_common_irq_flags = ((common_irq_flags_ff & ~flag_clear) | flag_set) & COMMON_VALID;
   assign sock_drop            = ~sock_irq_any & ~sock_irq_evt;
   // New event wins over the auto-clear of a silent socket
   assign nxt_socket_irq_summary = sock_irq_evt | (socket_irq_summary_ff & sock_irq_any);

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         common_irq_flags_ff    <= RST_ZERO8;
         common_irq_mask_ff     <= RST_ZERO8;
         socket_irq_mask_ff     <= RST_ZERO8;
         socket_irq_summary_ff  <= RST_ZERO8;
         retry_timeout_value_ff <= RST_RTR;
         retry_count_ff         <= RST_RETRY_COUNT;
         ppp_auth_type_ff       <= RST_ZERO16;
         ppp_auth_algorithm_ff  <= RST_ZERO8;
         lcp_echo_interval_ff   <= RST_ZERO8;
         lcp_magic_value_ff     <= RST_ZERO8;
         irq_reassert_wait_ff   <= RST_ZERO16;
         rdata_ff               <= RST_ZERO8;
      end else begin
         common_irq_flags_ff   <= nxt_common_irq_flags;
         socket_irq_summary_ff <= nxt_socket_irq_summary;
         rdata_ff              <= nxt_rdata;
         if (wr_at(bus_req, OFS_COMMON_MASK)) begin
            common_irq_mask_ff <= bus_req.wdata & COMMON_VALID;
         end
         if (wr_at(bus_req, OFS_SOCK_MASK)) begin
            socket_irq_mask_ff <= bus_req.wdata;
         end
         if (wr_at(bus_req, OFS_RTR_HI)) begin
            retry_timeout_value_ff[15:8] <= bus_req.wdata;
         end
         if (wr_at(bus_req, OFS_RTR_LO)) begin
            retry_timeout_value_ff[7:0] <= bus_req.wdata;
         end
         if (wr_at(bus_req, OFS_RETRY_COUNT)) begin
            retry_count_ff <= bus_req.wdata;
         end
         if (wr_at(bus_req, OFS_LCP_INTERVAL)) begin
            lcp_echo_interval_ff <= bus_req.wdata;
         end
         if (wr_at(bus_req, OFS_LCP_MAGIC)) begin
            lcp_magic_value_ff <= bus_req.wdata;
         end
         if (wr_at(bus_req, OFS_WAIT_HI)) begin
            irq_reassert_wait_ff[15:8] <= bus_req.wdata;
         end
         if (wr_at(bus_req, OFS_WAIT_LO)) begin
            irq_reassert_wait_ff[7:0] <= bus_req.wdata;
         end
         // Negotiation results come from the PPPoE engine, never from the bus
         if (ppp_info.load) begin
            ppp_auth_type_ff      <= ppp_info.auth_type;
            ppp_auth_algorithm_ff <= ppp_info.algo;
         end
      end
   end

   // ***********************************************************
   // Read selection
   // ***********************************************************
   always_comb begin
      nxt_rdata = 8'h00;
      if (bus_req.rd) begin
         case (bus_req.addr)
            OFS_COMMON_FLAGS: nxt_rdata = common_irq_flags_ff;
            OFS_SOCK_MASK:    nxt_rdata = socket_irq_mask_ff;
            OFS_RTR_HI:       nxt_rdata = retry_timeout_value_ff[15:8];
            OFS_RTR_LO:       nxt_rdata = retry_timeout_value_ff[7:0];
            OFS_RETRY_COUNT:  nxt_rdata = retry_count_ff;
            OFS_AUTH_HI:      nxt_rdata = ppp_auth_type_ff[15:8];
            OFS_AUTH_LO:      nxt_rdata = ppp_auth_type_ff[7:0];
            OFS_AUTH_ALGO:    nxt_rdata = ppp_auth_algorithm_ff;
            OFS_CHIP_REV:     nxt_rdata = CHIP_REV_CODE;
            OFS_LCP_INTERVAL: nxt_rdata = lcp_echo_interval_ff;
            OFS_LCP_MAGIC:    nxt_rdata = lcp_magic_value_ff;
            OFS_WAIT_HI:      nxt_rdata = irq_reassert_wait_ff[15:8];
            OFS_WAIT_LO:      nxt_rdata = irq_reassert_wait_ff[7:0];
            OFS_SOCK_SUMMARY: nxt_rdata = socket_irq_summary_ff;
            OFS_COMMON_MASK:  nxt_rdata = common_irq_mask_ff;
            default:          nxt_rdata = 8'h00;
         endcase
      end
   end

   // ***********************************************************
   // Interrupt pin with reassert wait
   // ***********************************************************
   logic [9:0]   pend;
   logic [9:0]   pend_ff;
   logic [7:0]   common_pend;
   logic         irq_req;
   logic         src_cleared;
   logic         irq_n_ff;
   logic [15:0]  gap_ff;

   assign common_pend = common_irq_flags_ff & common_irq_mask_ff & COMMON_VALID;
   // Only the two defined common bits join the eight socket bits
   assign pend        = {common_pend[BIT_IP_CONFLICT], common_pend[BIT_PPP_CLOSE],
                         socket_irq_summary_ff & socket_irq_mask_ff};
   assign irq_req     = |pend;
   // Any source dropping releases the pin so the host sees a fresh edge
   assign src_cleared = |(pend_ff & ~pend);

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         pend_ff  <= 10'h000;
         irq_n_ff <= 1'b1;
         gap_ff   <= RST_ZERO16;
      end else begin
         pend_ff <= pend;
         if (!irq_n_ff) begin
            if (!irq_req || src_cleared) begin
               irq_n_ff <= 1'b1;
               gap_ff   <= irq_reassert_wait_ff;
            end
         end else if (irq_req && (gap_ff == 16'h0000)) begin
            irq_n_ff <= 1'b0;
         end else if (gap_ff != 16'h0000) begin
            gap_ff <= gap_ff - 16'h0001;
         end
      end
   end

   // ***********************************************************
   // 100us tick
   // ***********************************************************
   logic [TICK_W-1:0] tick_cnt_ff;
   logic              tick_ff;

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         tick_cnt_ff <= '0;
         tick_ff     <= 1'b0;
      end else begin
         tick_ff <= (tick_cnt_ff == TICK_W'(TICK_CYCLES - 1));
         if (tick_cnt_ff == TICK_W'(TICK_CYCLES - 1)) begin
            tick_cnt_ff <= '0;
         end else begin
            tick_cnt_ff <= tick_cnt_ff + TICK_W'(1);
         end
      end
   end

   // ***********************************************************
   // Retry timer shared by address requests and TCP segments
   // ***********************************************************
   retry_state_t state_ff;
   logic [15:0]  period_ff;
   logic [15:0]  remain_ff;
   logic [7:0]   attempt_ff;
   logic         tcp_ff;
   retry_stat_t  stat_ff;
   logic [16:0]  doubled;
   logic [15:0]  nxt_period;
   logic         expire;
   logic         final_expire;

   assign doubled      = {period_ff, 1'b0};
   // Doubling stops at the last value that still fits in 16 bits
   assign nxt_period   = (tcp_ff && (doubled <= RTR_CAP)) ? doubled[15:0] : period_ff;
   assign expire       = (state_ff == RS_WAIT) && tick_ff && (remain_ff <= 16'h0001) && !retry_ctl.ack;
   assign final_expire = expire && (attempt_ff == retry_count_ff);

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         state_ff   <= RS_IDLE;
         period_ff  <= RST_ZERO16;
         remain_ff  <= RST_ZERO16;
         attempt_ff <= RST_ZERO8;
         tcp_ff     <= 1'b0;
         stat_ff    <= '0;
      end else begin
         stat_ff.retransmit <= 1'b0;
         stat_ff.timeout    <= 1'b0;
         stat_ff.tcp_close  <= 1'b0;
         if (retry_ctl.start) begin
            state_ff   <= RS_WAIT;
            period_ff  <= retry_timeout_value_ff;
            remain_ff  <= retry_timeout_value_ff;
            attempt_ff <= 8'h00;
            tcp_ff     <= retry_ctl.is_tcp;
         end else begin
            unique case (state_ff)
               RS_IDLE: begin
                  remain_ff <= remain_ff;
               end
               RS_WAIT: begin
                  if (retry_ctl.ack) begin
                     state_ff <= RS_IDLE;
                  end else if (final_expire) begin
                     state_ff          <= RS_IDLE;
                     stat_ff.timeout   <= 1'b1;
                     stat_ff.tcp_close <= tcp_ff;
                  end else if (expire) begin
                     stat_ff.retransmit <= 1'b1;
                     attempt_ff         <= attempt_ff + 8'h01;
                     period_ff          <= nxt_period;
                     remain_ff          <= nxt_period;
                  end else if (tick_ff) begin
                     remain_ff <= remain_ff - 16'h0001;
                  end
               end
            endcase
         end
         stat_ff.busy <= retry_ctl.start || ((state_ff == RS_WAIT) && !retry_ctl.ack && !final_expire);
      end
   end

   // ***********************************************************
   // Echo request interval
   // ***********************************************************
   logic [7:0]   lcp_sub_ff;
   logic [7:0]   lcp_units_ff;
   logic         lcp_echo_ff;
   logic         lcp_on;
   logic         lcp_unit;

   assign lcp_on   = ppp_mode && (lcp_echo_interval_ff != 8'h00);
   assign lcp_unit = tick_ff && (lcp_sub_ff == LCP_TICKS - 8'h01);

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         lcp_sub_ff   <= RST_ZERO8;
         lcp_units_ff <= RST_ZERO8;
         lcp_echo_ff  <= 1'b0;
      end else begin
         lcp_echo_ff <= 1'b0;
         if (!lcp_on) begin
            lcp_sub_ff   <= RST_ZERO8;
            lcp_units_ff <= RST_ZERO8;
         end else if (tick_ff) begin
            lcp_sub_ff <= lcp_unit ? 8'h00 : lcp_sub_ff + 8'h01;
            if (lcp_unit && (lcp_units_ff == lcp_echo_interval_ff - 8'h01)) begin
               lcp_units_ff <= 8'h00;
               lcp_echo_ff  <= 1'b1;
            end else if (lcp_unit) begin
               lcp_units_ff <= lcp_units_ff + 8'h01;
            end
         end
      end
   end

   assign rdata        = rdata_ff;
   assign irq_out_n    = irq_n_ff;
   assign retry_stat   = stat_ff;
   assign lcp_echo_req = lcp_echo_ff;
   assign lcp_magic    = lcp_magic_value_ff;

   // ***********************************************************
   // Assertions
   // ***********************************************************
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!arst_n);

   sequence s_high16;
      irq_n_ff [*8] ##1 irq_n_ff [*8];
   endsequence

   property p_irq_assert;
      irq_n_ff && irq_req && (gap_ff == 16'h0000) |=> !irq_n_ff;
   endproperty
   a_irq_assert: assert property (p_irq_assert) else $error("pin not asserted for pending source");

   property p_masked_quiet;
      irq_n_ff && !irq_req |=> irq_n_ff;
   endproperty
   a_masked_quiet: assert property (p_masked_quiet) else $error("pin asserted with nothing unmasked");

   property p_hold_low;
      !irq_n_ff && irq_req && !src_cleared |=> !irq_n_ff;
   endproperty
   a_hold_low: assert property (p_hold_low) else $error("pin released while source held");

   property p_wait_16;
      $rose(irq_n_ff) && (irq_reassert_wait_ff == 16'h000F) |-> s_high16;
   endproperty
   a_wait_16: assert property (p_wait_16) else $error("reassert wait shorter than 16 clocks");

   property p_wait_1;
      $rose(irq_n_ff) && (gap_ff == 16'h0000) && irq_req && !src_cleared |=> !irq_n_ff;
   endproperty
   a_wait_1: assert property (p_wait_1) else $error("reassert not one clock after release");

   property p_summary_set;
      (sock_irq_evt != 8'h00) |=> ((socket_irq_summary_ff & $past(sock_irq_evt)) == $past(sock_irq_evt));
   endproperty
   a_summary_set: assert property (p_summary_set) else $error("summary bit missed socket event");

   property p_summary_clear;
      1'b1 |=> ((socket_irq_summary_ff & $past(sock_drop)) == 8'h00);
   endproperty
   a_summary_clear: assert property (p_summary_clear) else $error("summary bit kept for silent socket");

   property p_conflict_flag;
      ip_conflict_evt |=> common_irq_flags_ff[BIT_IP_CONFLICT] ##1 1'b1;
   endproperty
   a_conflict_flag: assert property (p_conflict_flag) else $error("conflict flag lost");

   property p_reserved_zero;
      (common_irq_flags_ff & ~COMMON_VALID) == 8'h00 && (common_irq_mask_ff & ~COMMON_VALID) == 8'h00;
   endproperty
   a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");

   property p_final_timeout;
      final_expire && !retry_ctl.start |=> stat_ff.timeout && (stat_ff.tcp_close == $past(tcp_ff));
   endproperty
   a_final_timeout: assert property (p_final_timeout) else $error("final timeout not reported");

   property p_close_with_timeout;
      stat_ff.tcp_close |-> stat_ff.timeout && !stat_ff.retransmit;
   endproperty
   a_close_with_timeout: assert property (p_close_with_timeout) else $error("close without timeout");

   property p_no_early_timeout;
      expire && (attempt_ff != retry_count_ff) && !retry_ctl.start |=> stat_ff.retransmit && !stat_ff.timeout;
   endproperty
   a_no_early_timeout: assert property (p_no_early_timeout) else $error("timeout before last period");

endmodule : irq_retry_ctrl

// [test/sock_flag_model.sv]
// Socket flag holder standing in for the socket side of the interrupt path
module sock_flag_model (
   input  wire logic       ref_clk,
   input  wire logic       arst_n,
   input  wire logic [7:0] raise,
   input  wire logic [7:0] clear,
   output logic      [7:0] evt_ff,
   output logic      [7:0] any_ff
);
   timeunit 1ns;
   timeprecision 1ps;
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         evt_ff <= 8'h00;
         any_ff <= 8'h00;
      end else begin
         evt_ff <= raise;
         any_ff <= (any_ff | raise) & ~clear;
      end
   end
endmodule : sock_flag_model

// [test/irq_retry_ctrl_tb.sv]
// Self-checking bench for the common interrupt and retry block
module irq_retry_ctrl_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import irq_retry_pkg::*;
   localparam logic [7:0] REV = 8'h3C; // Arbitrary value
   logic        ref_clk = 1'b0;
   logic        arst_n = 1'b0;
   reg_req_t    req = '0;
   logic [7:0]  rdata, cevt = 8'h00, raise = 8'h00, clear = 8'h00, s_evt, s_any, magic;
   ppp_info_t   info = '0;
   logic        ppp_mode = 1'b0, echo, irq_n;
   retry_ctl_t  ctl = '0;
   retry_stat_t stat, s;
   int          n_mismatch = 0, compares = 0, n;
   logic [15:0] ra [16] = '{16'h0017, 16'h0018, 16'h0019, 16'h001C, 16'h001D, 16'h001E, 16'h001F, 16'h0028,
                            16'h0029, 16'h0030, 16'h0031, 16'h0034, 16'h0036, 16'h0015, 16'h0016, 16'h00FF};
   logic [7:0]  rv [16] = '{8'h07, 8'hD0, 8'h08, 8'h00, 8'h00, 8'h00, REV, 8'h00,
                            8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
   always #2.5 ref_clk = ~ref_clk;
   irq_retry_ctrl #(.TICK_CYCLES(4), .CHIP_REV_CODE(REV)) i_irq_retry_ctrl (.ref_clk(ref_clk), .arst_n(arst_n),
      .bus_req(req), .rdata(rdata), .ip_conflict_evt(cevt[7]), .ppp_close_evt(cevt[5]), .sock_irq_evt(s_evt),
      .sock_irq_any(s_any), .ppp_info(info), .ppp_mode(ppp_mode), .retry_ctl(ctl), .retry_stat(stat),
      .lcp_echo_req(echo), .lcp_magic(magic), .irq_out_n(irq_n));
   sock_flag_model i_sock_flag_model (.ref_clk(ref_clk), .arst_n(arst_n), .raise(raise), .clear(clear),
      .evt_ff(s_evt), .any_ff(s_any));
   // ***********************************************************
   // Bus and compare tasks
   // ***********************************************************
   task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
      compares++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge ref_clk) req <= '{1'b1, 1'b0, a, d};
      @(posedge ref_clk) req <= '0;
   endtask : wr
   task automatic rd_chk(input logic [15:0] a, input logic [7:0] e);
      @(posedge ref_clk) req <= '{1'b0, 1'b1, a, 8'h00};
      @(posedge ref_clk) req <= '0;
      #1 chk($sformatf("reg %h", a), {8'h00, e}, {8'h00, rdata});
   endtask : rd_chk
   task automatic pin(input logic e);
      repeat (3) @(posedge ref_clk);
      #1 chk("irq pin", {15'h0, e}, {15'h0, irq_n});
   endtask : pin
   task automatic nxt_evt(input int lim);
      n = 0;
      do begin
         @(posedge ref_clk);
         #1 n++;
         s = stat;
      end while (s.retransmit !== 1'b1 && s.timeout !== 1'b1 && n < lim);
   endtask : nxt_evt
   task automatic start(input logic tcp);
      @(posedge ref_clk) ctl <= '{1'b1, tcp, 1'b0};
      @(posedge ref_clk) ctl <= '0;
   endtask : start
   task automatic close_out();
      $display("mismatches %0d compares %0d", n_mismatch, compares);
      if (n_mismatch == 0 && compares > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : close_out
   // ***********************************************************
   // Tests
   // ***********************************************************
   initial begin
      repeat (16) @(posedge ref_clk);
      arst_n <= 1'b1;
      for (int i = 0; i < 16; i++) rd_chk(ra[i], rv[i]);
      wr(OFS_AUTH_HI, 8'hFF);
      rd_chk(OFS_AUTH_HI, 8'h00);
      for (int i = 0; i < 2; i++) begin
         @(posedge ref_clk) info <= '{1'b1, (i == 0) ? AUTH_PAP : AUTH_CHAP, 8'h11};
         @(posedge ref_clk) info <= '0;
         rd_chk(OFS_AUTH_HI, (i == 0) ? 8'hC0 : 8'hC2);
         rd_chk(OFS_AUTH_LO, 8'h23);
         rd_chk(OFS_AUTH_ALGO, 8'h11);
      end
      wr(OFS_COMMON_MASK, 8'hFF);
      rd_chk(OFS_COMMON_MASK, 8'hA0);
      wr(OFS_COMMON_MASK, 8'h00);
      foreach (ra[b]) if (b == 7 || b == 5) begin
         @(posedge ref_clk) cevt <= 8'h01 << b;
         @(posedge ref_clk) cevt <= 8'h00;
         pin(1'b1);
         rd_chk(OFS_COMMON_FLAGS, 8'h01 << b);
         wr(OFS_COMMON_MASK, 8'h01 << b);
         pin(1'b0);
         wr(OFS_COMMON_FLAGS, 8'h01 << b);
         pin(1'b1);
         wr(OFS_COMMON_MASK, 8'h00);
      end
      wr(OFS_SOCK_MASK, 8'h03);
      // Wait zero first, so the gap counter is idle when the wait of 15 starts
      for (int w = 0; w < 2; w++) begin
         wr(OFS_WAIT_LO, (w == 0) ? 8'h00 : 8'h0F);
         @(posedge ref_clk) raise <= 8'h03;
         @(posedge ref_clk) raise <= 8'h00;
         pin(1'b0);
         rd_chk(OFS_SOCK_SUMMARY, 8'h03);
         @(posedge ref_clk) clear <= 8'h01;
         @(posedge ref_clk) clear <= 8'h00;
         n = 0;
         while (irq_n !== 1'b1 && n < 20) begin @(posedge ref_clk); #1 n++; end
         n = 0;
         while (irq_n !== 1'b0 && n < 40) begin @(posedge ref_clk); #1 n++; end
         chk("reassert gap", (w == 0) ? 16'd1 : 16'd16, 16'(n));
         rd_chk(OFS_SOCK_SUMMARY, 8'h02);
         @(posedge ref_clk) clear <= 8'h02;
         @(posedge ref_clk) clear <= 8'h00;
         pin(1'b1);
      end
      wr(OFS_RTR_HI, 8'h00);
      wr(OFS_RTR_LO, 8'h02);
      wr(OFS_RETRY_COUNT, 8'h00);
      start(1'b0);
      nxt_evt(100);
      chk("arp final", 16'h0002, {13'h0, s.retransmit, s.timeout, s.tcp_close});
      wr(OFS_RETRY_COUNT, 8'h02);
      start(1'b1);
      nxt_evt(100);
      chk("tcp resend", 16'h0004, {13'h0, s.retransmit, s.timeout, s.tcp_close});
      nxt_evt(100);
      chk("doubled period", 16'd16, 16'(n));
      nxt_evt(100);
      chk("second doubling", 16'd32, 16'(n));
      chk("tcp final", 16'h0003, {13'h0, s.retransmit, s.timeout, s.tcp_close});
      start(1'b0);
      @(posedge ref_clk) ctl <= '{1'b0, 1'b0, 1'b1};
      @(posedge ref_clk) ctl <= '0;
      nxt_evt(60);
      chk("answered attempt", 16'h0000, {13'h0, s.retransmit, s.timeout, s.busy});
      wr(OFS_LCP_MAGIC, 8'h6B);
      @(posedge ref_clk);
      #1 chk("magic", 16'h006B, {8'h00, magic});
      @(posedge ref_clk) ppp_mode <= 1'b1;
      wr(OFS_LCP_INTERVAL, 8'h01);
      for (int k = 0; k < 2; k++) begin
         n = 0;
         do begin @(posedge ref_clk); #1 n++; end while (echo !== 1'b1 && n < 1200);
      end
      chk("echo period", 16'd1000, 16'(n));
      close_out();
   end
   initial begin
      #(40000 * 5);
      n_mismatch++;
      close_out();
   end
endmodule : irq_retry_ctrl_tb
